/* cst_defs.svh */
// constants for the clock and stopwatch timer: register indexes,
// field positions, reset values and tick arithmetic
// assumes: included by bare name after the package
`ifndef CST_DEFS_SVH
`define CST_DEFS_SVH

// register indexes, byte address is four times the index
`define CST_IDX_DIV   12'h2e0
`define CST_IDX_SWL   12'h2e1
`define CST_IDX_SWH   12'h2e2
`define CST_IDX_SWMSK 12'h2e6
`define CST_IDX_TKMSK 12'h2e8
`define CST_IDX_TKEV  12'h2e9
`define CST_IDX_SWEV  12'h2ea
`define CST_IDX_CTL   12'h2ee

// control register field positions
`define CST_BIT_TMCLR 3
`define CST_BIT_STOPWATCH_RUN_CONTROL 2
`define CST_BIT_SWCLR 1

// divider stages that raise events (32, 8, 2 Hz)
`define CST_BIT_32HZ  2
`define CST_BIT_8HZ   4
`define CST_BIT_2HZ   6

// reset values
`define CST_RST_NIB   4'h0
`define CST_RST_DIV   7'h00
`define CST_RST_ACC   8'h00

// hundredths pacing: 100 steps per 256 ticks
`define CST_ACC_STEP  9'h064
`define CST_BCD_MAX   4'h9

`endif

/* cst_pkg.sv */
// types shared by the clock and stopwatch timer
// assumes: compiled before every module that uses it
package cst_pkg;
  typedef logic [3:0]  cst_bcd_t;
  typedef logic [6:0]  cst_div_t;
  typedef logic [11:0] cst_idx_t;
endpackage : cst_pkg

/* cst_timer.sv */
// clock timer tail and two-digit bcd stopwatch, apb register slave
// assumes: i_tick_256hz is the prescaler square wave from another domain,
// i_ref_clk far faster than 256 hz, cpu is the only bus master
//
// Summary of operation
// [R1] divider 16-2 hz stages read only
// [R2] three tick masks, read/write, reset zero
// [R3] falling 32/8/2 hz edge sets event flag
// [R4] tick flags clear on read, writes ignored
// [R5] software reads tick flags only interrupts disabled
// [R6] software writes tick masks only interrupts disabled
// [R7] divider clear bit clears, reads zero
// [R8] divider clear may set a flag
// [R9] 2 hz stage clocks the watchdog
// [R10] two cascaded bcd digits from 256 hz
// [R11] hundredths steps every 2 or 3 ticks
// [R12] tenths counts carries, overflow gives 1 hz
// [R13] digit rollovers raise 10 hz / 1 hz flags
// [R14] stopwatch flags set regardless of masks
// [R15] reading flags clears the bits read
// [R16] both digits read only, reset zero
// [R17] two stopwatch masks, read/write, reset zero
// [R18] run bit advances or freezes digits
// [R19] stopwatch clear bit zeroes digits, reads zero
// [R20] software stop-read-restart within 976 us
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "cst_defs.svh"

module cst_timer (
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  input  wire logic        i_tick_256hz,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [13:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic      [2:0]  o_tick_req,
  output logic      [1:0]  o_sw_req,
  output logic             o_wdt_clk
);

  // ******************************************************
  // helpers
  // ******************************************************
  function automatic cst_pkg::cst_bcd_t bcd_inc(input cst_pkg::cst_bcd_t d);
    bcd_inc = (d == `CST_BCD_MAX) ? `CST_RST_NIB : 4'(d + 4'h1);
  endfunction : bcd_inc

  function automatic logic is_idx(input cst_pkg::cst_idx_t a,
                                  input cst_pkg::cst_idx_t b);
    is_idx = (a == b);
  endfunction : is_idx

  // ******************************************************
  // declarations
  // ******************************************************
  cst_pkg::cst_idx_t idx;
  logic              setup;
  logic              done;
  logic              wr_done;
  logic              rd_done;
  logic              tk_s1;
  logic              tk_s2;
  logic              tk_s3;
  logic              tick;
  cst_pkg::cst_div_t div_cnt;
  cst_pkg::cst_div_t next_div;
  logic              div_clr;
  logic [2:0]        tick_fall;
  logic [2:0]        ev_tick;
  logic [2:0]        mask_tick;
  logic [1:0]        ev_sw;
  logic [1:0]        mask_sw;
  logic              sw_run;
  logic              sw_clr;
  logic [7:0]        sw_acc;
  logic [8:0]        acc_sum;
  logic              sw_step;
  cst_pkg::cst_bcd_t hund;
  cst_pkg::cst_bcd_t tenth;
  logic              hund_wrap;
  logic              tenth_wrap;
  logic [31:0]       next_rdata;
  logic              next_hit;

  // ******************************************************
  // apb decode
  // ******************************************************
  assign idx     = i_paddr[13:2];
  assign setup   = i_psel & ~i_penable;
  assign done    = i_psel & i_penable & o_pready;
  assign wr_done = done & i_pwrite;
  assign rd_done = done & ~i_pwrite;

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_hit   = 1'b1;
    case (idx)
      `CST_IDX_DIV:   next_rdata[3:0] = div_cnt[6:3]; // [R1]
      `CST_IDX_SWL:   next_rdata[3:0] = hund; // [R16]
      `CST_IDX_SWH:   next_rdata[3:0] = tenth; // [R16]
      `CST_IDX_SWMSK: next_rdata[1:0] = mask_sw;
      `CST_IDX_TKMSK: next_rdata[2:0] = mask_tick;
      `CST_IDX_TKEV:  next_rdata[2:0] = ev_tick;
      `CST_IDX_SWEV:  next_rdata[1:0] = ev_sw;
      // clear bits always read zero
      `CST_IDX_CTL:   next_rdata[`CST_BIT_STOPWATCH_RUN_CONTROL] = sw_run; // [R7] [R19]
      default:        next_hit = 1'b0;
    endcase
  end

  // ready one cycle after setup: zero-wait access phase
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pready <= 1'b0;
    end else if (i_ce) begin
      o_pready <= setup;
    end
  end

  // read data snapshot taken in the setup cycle
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (i_ce && setup) begin
      o_prdata  <= i_pwrite ? 32'h0000_0000 : next_rdata;
      o_pslverr <= ~next_hit;
    end
  end

  // ******************************************************
  // 256 hz input synchroniser and edge
  // ******************************************************
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tk_s1 <= 1'b0;
      tk_s2 <= 1'b0;
      tk_s3 <= 1'b0;
    end else if (i_ce) begin
      tk_s1 <= i_tick_256hz;
      tk_s2 <= tk_s1;
      tk_s3 <= tk_s2;
    end
  end

  assign tick = tk_s2 & ~tk_s3;

  // ******************************************************
  // clock timer divider
  // ******************************************************
  assign div_clr = wr_done & is_idx(idx, `CST_IDX_CTL)
                   & i_pwdata[`CST_BIT_TMCLR];

  always_comb begin
    if (div_clr) begin
      next_div = `CST_RST_DIV; // [R7]
    end else begin
      next_div = 7'(div_cnt + {6'h00, tick});
    end
  end

  // a clear can drop a high stage and so raise its event
  assign tick_fall[0] = div_cnt[`CST_BIT_32HZ] & ~next_div[`CST_BIT_32HZ]; // [R3] [R8]
  assign tick_fall[1] = div_cnt[`CST_BIT_8HZ] & ~next_div[`CST_BIT_8HZ]; // [R3] [R8]
  assign tick_fall[2] = div_cnt[`CST_BIT_2HZ] & ~next_div[`CST_BIT_2HZ]; // [R3] [R8]

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_cnt <= `CST_RST_DIV;
    end else if (i_ce) begin
      div_cnt <= next_div; // [R1] [R7]
    end
  end

  // 2 hz stage to watchdog, may give an extra count on clear
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wdt_clk <= 1'b0;
    end else if (i_ce) begin
      o_wdt_clk <= next_div[`CST_BIT_2HZ]; // [R9]
    end
  end

  // ******************************************************
  // tick events and masks
  // ******************************************************
  // only bits that were returned are cleared; a new event wins
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ev_tick <= 3'h0;
    end else if (i_ce) begin
      if (rd_done && is_idx(idx, `CST_IDX_TKEV)) begin
        ev_tick <= (ev_tick & ~o_prdata[2:0]) | tick_fall; // [R4] [R15]
      end else begin
        ev_tick <= ev_tick | tick_fall; // [R3]
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mask_tick <= 3'h0;
    end else if (i_ce && wr_done && is_idx(idx, `CST_IDX_TKMSK)) begin
      mask_tick <= i_pwdata[2:0]; // [R2]
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_tick_req <= 3'h0;
    end else if (i_ce) begin
      o_tick_req <= ev_tick & mask_tick; // [R2]
    end
  end

  // ******************************************************
  // stopwatch control
  // ******************************************************
  assign sw_clr = wr_done & is_idx(idx, `CST_IDX_CTL)
                  & i_pwdata[`CST_BIT_SWCLR];

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sw_run <= 1'b0;
    end else if (i_ce && wr_done && is_idx(idx, `CST_IDX_CTL)) begin
      sw_run <= i_pwdata[`CST_BIT_STOPWATCH_RUN_CONTROL]; // [R18]
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mask_sw <= 2'h0;
    end else if (i_ce && wr_done && is_idx(idx, `CST_IDX_SWMSK)) begin
      mask_sw <= i_pwdata[1:0]; // [R17]
    end
  end

  // ******************************************************
  // stopwatch pacing and digits
  // ******************************************************
  // 100 steps per 256 ticks: gaps of 2 or 3, decades of 25 or 26
  assign acc_sum    = {1'b0, sw_acc} + `CST_ACC_STEP;
  assign sw_step    = tick & sw_run & acc_sum[8] & ~sw_clr; // [R10] [R11]
  assign hund_wrap  = sw_step & (hund == `CST_BCD_MAX); // [R13]
  assign tenth_wrap = hund_wrap & (tenth == `CST_BCD_MAX); // [R12] [R13]

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sw_acc <= `CST_RST_ACC;
    end else if (i_ce) begin
      if (sw_clr) begin
        sw_acc <= `CST_RST_ACC; // [R19]
      end else if (tick && sw_run) begin
        sw_acc <= acc_sum[7:0]; // [R11]
      end
    end
  end

  // stopped digits hold and resume from the held value
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hund  <= `CST_RST_NIB;
      tenth <= `CST_RST_NIB;
    end else if (i_ce) begin
      if (sw_clr) begin
        hund  <= `CST_RST_NIB; // [R19]
        tenth <= `CST_RST_NIB; // [R19]
      end else if (sw_step) begin
        hund <= bcd_inc(hund); // [R10] [R18] [R20]
        if (hund_wrap) begin
          tenth <= bcd_inc(tenth); // [R12]
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ev_sw <= 2'h0;
    end else if (i_ce) begin
      if (rd_done && is_idx(idx, `CST_IDX_SWEV)) begin
        ev_sw <= (ev_sw & ~o_prdata[1:0]) | {tenth_wrap, hund_wrap}; // [R15]
      end else begin
        ev_sw <= ev_sw | {tenth_wrap, hund_wrap}; // [R13] [R14]
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sw_req <= 2'h0;
    end else if (i_ce) begin
      o_sw_req <= ev_sw & mask_sw; // [R17]
    end
  end

  // ******************************************************
  // assertions
  // ******************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  a_tick_fall_set: assert property ( // [R3]
    i_ce && tick_fall[0] |=> ev_tick[0]
  ) else $error("32 hz event flag not set on falling edge");

  a_tick_read_clr: assert property ( // [R4]
    i_ce && rd_done && is_idx(idx, `CST_IDX_TKEV) && tick_fall == 3'h0
    |=> (ev_tick & $past(o_prdata[2:0])) == 3'h0
  ) else $error("tick flag survived its read");

  a_div_clear: assert property ( // [R7]
    i_ce && div_clr |=> div_cnt == 7'h00 ##1 (div_cnt <= 7'h01)
  ) else $error("divider not cleared by write");

  a_ctl_reads_zero: assert property ( // [R19]
    i_ce && setup && !i_pwrite && is_idx(idx, `CST_IDX_CTL)
    |=> o_prdata[`CST_BIT_TMCLR] == 1'b0 && o_prdata[`CST_BIT_SWCLR] == 1'b0
  ) else $error("clear bits read as one");

  a_bcd_range: assert property ( // [R10]
    hund <= `CST_BCD_MAX && tenth <= `CST_BCD_MAX
  ) else $error("stopwatch digit out of bcd range");

  a_sw_freeze: assert property ( // [R18]
    i_ce && !sw_run && !sw_clr |=> $stable(hund) && $stable(tenth)
  ) else $error("stopped stopwatch moved");

  a_hund_roll: assert property ( // [R13]
    i_ce && hund_wrap |=> hund == 4'h0 && ev_sw[0]
  ) else $error("hundredths rollover without flag");

  a_tenth_roll: assert property ( // [R12]
    i_ce && tenth_wrap |=> tenth == 4'h0 && ev_sw[1] && hund == 4'h0
  ) else $error("tenths rollover without 1 hz flag");

  a_sw_clr_digits: assert property ( // [R19]
    i_ce && sw_clr |=> hund == 4'h0 && tenth == 4'h0 && sw_acc == 8'h00
  ) else $error("stopwatch clear did not zero digits");

  a_step_spacing: assert property ( // [R11]
    i_ce && sw_step |=> !sw_step [*2]
  ) else $error("hundredths stepped too close together");

  a_sw_req_mask: assert property ( // [R17]
    i_ce && ev_sw[1] && mask_sw[1] |=> o_sw_req[1]
  ) else $error("enabled 1 hz event not requested");

  a_wdt_follow: assert property ( // [R9]
    i_ce |=> o_wdt_clk == div_cnt[`CST_BIT_2HZ]
  ) else $error("watchdog clock not following 2 hz stage");

  a_pready_once: assert property (
    i_ce && setup |=> o_pready ##1 (!o_pready || !$past(i_ce))
  ) else $error("ready not a single access cycle");

  a_ce_freeze: assert property (
    !i_ce |=> $stable(div_cnt) && $stable(hund) && $stable(ev_tick)
  ) else $error("state moved while clock enable low");

  c_tick_event: cover property (i_ce && |tick_fall);
  c_second_roll: cover property (i_ce && tenth_wrap);
  c_flag_read: cover property (rd_done && is_idx(idx, `CST_IDX_SWEV) && o_prdata[0]);
  c_div_clear: cover property (i_ce && div_clr && div_cnt[`CST_BIT_2HZ]);

endmodule : cst_timer
`default_nettype wire

/* cst_timer_tb_top.sv */
// self-checking bench for the clock and stopwatch timer
// assumes: cst_pkg and cst_timer compiled first, apb zero-wait slave
`timescale 1ns/100ps
`default_nettype none
`include "cst_defs.svh"

module cst_timer_tb_top;
  logic        clk;
  logic        nrst;
  logic        ce;
  logic        tick;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [13:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  tick_req;
  logic [1:0]  sw_req;
  logic        wdt_clk;
  logic [32:0] q[$];
  int          failures;
  int          n_checks;
  int          sw;
  logic [31:0] seed;
  logic [3:0]  mk;
  logic [3:0]  ms;
  cst_pkg::cst_idx_t ro[5];

  cst_timer uut (
    .i_ref_clk    (clk),
    .i_nrst       (nrst),
    .i_ce         (ce),
    .i_tick_256hz (tick),
    .i_psel       (psel),
    .i_penable    (penable),
    .i_pwrite     (pwrite),
    .i_paddr      (paddr),
    .i_pwdata     (pwdata),
    .o_prdata     (prdata),
    .o_pready     (pready),
    .o_pslverr    (pslverr),
    .o_tick_req   (tick_req),
    .o_sw_req     (sw_req),
    .o_wdt_clk    (wdt_clk)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] xrand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xrand

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input cst_pkg::cst_idx_t idx, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input cst_pkg::cst_idx_t idx, input logic [3:0] e);
    q.push_back({1'b0, 28'h0, e});
    apb(1'b0, idx, 32'h0);
  endtask : rd

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      repeat (4) @(posedge clk);
      tick <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask : ticks

  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  // read completions compared against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check({pslverr, prdata}, q.pop_front());
    end
  end

  // ****************************************
  // clock, reset, watchdog, sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end

  initial begin
    nrst = 1'b0; ce = 1'b1; tick = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 14'h0; pwdata = 32'h0; seed = 32'd95;
    failures = 0; n_checks = 0;
    ro = '{`CST_IDX_DIV, `CST_IDX_SWL, `CST_IDX_SWH, `CST_IDX_TKEV, `CST_IDX_SWEV};
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    foreach (ro[i]) rd(ro[i], 4'h0);
    rd(`CST_IDX_TKMSK, 4'h0);
    rd(`CST_IDX_SWMSK, 4'h0);
    rd(`CST_IDX_CTL, 4'h0);
    foreach (ro[i]) begin
      apb(1'b1, ro[i], 32'hf);
      rd(ro[i], 4'h0);
    end
    mk = 4'(xrand());
    ms = 4'(xrand());
    apb(1'b1, `CST_IDX_TKMSK, {28'h0, mk});
    rd(`CST_IDX_TKMSK, mk & 4'h7);
    apb(1'b1, `CST_IDX_SWMSK, {28'h0, ms});
    rd(`CST_IDX_SWMSK, ms & 4'h3);
    ticks(40);
    check(33'(tick_req), 33'(3'b011 & mk[2:0]));
    rd(`CST_IDX_DIV, 4'h5);
    rd(`CST_IDX_TKEV, 4'h3);
    rd(`CST_IDX_TKEV, 4'h0);
    ticks(24);
    check(33'(wdt_clk), 33'h1);
    ticks(64);
    check(33'(wdt_clk), 33'h0);
    rd(`CST_IDX_DIV, 4'h0);
    rd(`CST_IDX_TKEV, 4'h7);
    ticks(4);
    apb(1'b1, `CST_IDX_CTL, 32'h8);
    rd(`CST_IDX_CTL, 4'h0);
    rd(`CST_IDX_DIV, 4'h0);
    rd(`CST_IDX_TKEV, 4'h1);
    rd(`CST_IDX_TKEV, 4'h0);
    // clock enable low: eight ticks must leave the divider alone
    @(posedge clk);
    ce <= 1'b0;
    ticks(8);
    @(posedge clk);
    ce <= 1'b1;
    rd(`CST_IDX_DIV, 4'h0);
    apb(1'b1, `CST_IDX_CTL, 32'h6);
    rd(`CST_IDX_CTL, 4'h4);
    sw = 0;
    repeat (26) begin
      ticks(1);
      sw++;
      rd(`CST_IDX_SWL, 4'((sw * 100 / 256) % 10));
    end
    rd(`CST_IDX_SWH, 4'h1);
    check(33'(sw_req), 33'(2'b01 & ms[1:0]));
    rd(`CST_IDX_SWEV, 4'h1);
    rd(`CST_IDX_SWEV, 4'h0);
    apb(1'b1, `CST_IDX_CTL, 32'h0);
    rd(`CST_IDX_SWL, 4'h0);
    rd(`CST_IDX_SWH, 4'h1);
    ticks(10);
    rd(`CST_IDX_SWL, 4'h0);
    rd(`CST_IDX_SWH, 4'h1);
    apb(1'b1, `CST_IDX_CTL, 32'h4);
    ticks(256);
    sw = sw + 256;
    rd(`CST_IDX_SWL, 4'((sw * 100 / 256) % 10));
    rd(`CST_IDX_SWH, 4'((sw * 100 / 2560) % 10));
    check(33'(sw_req), 33'(2'b11 & ms[1:0]));
    rd(`CST_IDX_SWEV, 4'h3);
    apb(1'b1, `CST_IDX_CTL, 32'h6);
    ticks(3);
    rd(`CST_IDX_SWL, 4'h1);
    apb(1'b1, `CST_IDX_CTL, 32'h2);
    rd(`CST_IDX_CTL, 4'h0);
    ticks(5);
    rd(`CST_IDX_SWL, 4'h0);
    rd(`CST_IDX_SWH, 4'h0);
    q.push_back({1'b1, 32'h0});
    apb(1'b0, 12'h2ff, 32'h0);
    repeat (3) @(posedge clk);
    summarize();
  end
endmodule : cst_timer_tb_top

`default_nettype wire
